// File: psi_pkg.sv
// shared constants and types for the boot status indicator
package psi_pkg;

  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned QUARTER_MS   = 250;
  localparam int unsigned QUARTER_CYC  = CLK_HZ / 1000 * QUARTER_MS;
  localparam int unsigned BEEP_HZ      = 932;
  localparam int unsigned HIGH_HZ      = 2000;
  localparam int unsigned LOW_HZ       = 1500;
  localparam int unsigned HALF_BEEP    = CLK_HZ / (2 * BEEP_HZ);
  localparam int unsigned HALF_HIGH    = CLK_HZ / (2 * HIGH_HZ);
  localparam int unsigned HALF_LOW     = CLK_HZ / (2 * LOW_HZ);

  // last quarter index of each pattern and blink timings, in quarter seconds
  localparam logic [5:0] PROMPT_LAST   = 6'h01;
  localparam logic [5:0] UPDATE_LAST   = 6'h03;
  localparam logic [5:0] VIDEO_LAST    = 6'h19;
  localparam logic [5:0] MEMORY_LAST   = 6'h21;
  localparam logic [5:0] THERMAL_LAST  = 6'h1f;
  localparam logic [5:0] BLINK_PERIOD  = 6'h08;
  localparam logic [5:0] VIDEO_BLINKS  = 6'h10;
  localparam logic [5:0] MEMORY_BLINKS = 6'h18;

  localparam logic [15:0] CODE_ADDR    = 16'h0080;
  localparam logic [7:0]  CODE_RESET   = 8'h00;

  typedef enum logic [2:0] {
    PSI_IDLE    = 3'b000,
    PSI_PROMPT  = 3'b001,
    PSI_UPDATE  = 3'b010,
    PSI_VIDEO   = 3'b011,
    PSI_MEMORY  = 3'b100,
    PSI_THERMAL = 3'b101
  } psi_pat_t;

  typedef enum logic [1:0] {
    PSI_TONE_OFF  = 2'b00,
    PSI_TONE_BEEP = 2'b01,
    PSI_TONE_HIGH = 2'b10,
    PSI_TONE_LOW  = 2'b11
  } psi_tone_t;

endpackage

// File: psi_tone_gen.sv
// square wave tone generator with programmable half period
`timescale 1ns/100ps
module psi_tone_gen (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        toneEn,
  input  wire logic [23:0] halfPeriod,
  output logic             toneOut_q
);
  logic [23:0] halfCnt_q;
  wire         halfDone = (halfCnt_q >= halfPeriod - 24'h000001);

  // a disabled tone parks low so the next beep starts on a clean edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !toneEn) begin
      halfCnt_q <= 24'h000000;
      toneOut_q <= 1'b0;
    end else if (halfDone) begin
      halfCnt_q <= 24'h000000;
      toneOut_q <= !toneOut_q;
    end else begin
      halfCnt_q <= halfCnt_q + 24'h000001;
    end
  end

  tone_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    toneEn && halfCnt_q == 24'h000000 && $past(halfDone) && $past(toneEn)
    |-> toneOut_q != $past(toneOut_q))
    else $error("tone did not toggle at half period");

endmodule // psi_tone_gen

// File: psi_indicator.sv
// beep and blink pattern sequencer with progress code latch
`timescale 1ns/100ps
// Overview of operation
// - prompt: one half-second 932 Hz beep, no blink
// - update: silent, LED off then half-second blinks
// - video: two beeps, pause, played twice only
// - video: two blinks, pause, repeats forever
// - memory: three beeps, pause, repeats forever
// - memory: three blinks, pause, repeats forever
// - thermal: eight alternating high/low beeps, then shutdown
// - thermal: quarter-second blinks, two per beep
// - keep last code written to I/O address 0x0080 in progressCode_q
module psi_indicator import psi_pkg::*; #(
  parameter int unsigned QUARTER_CYCLES = psi_pkg::QUARTER_CYC,
  parameter int unsigned HALF_BEEP_CYC  = psi_pkg::HALF_BEEP,
  parameter int unsigned HALF_HIGH_CYC  = psi_pkg::HALF_HIGH,
  parameter int unsigned HALF_LOW_CYC   = psi_pkg::HALF_LOW
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              patReq,
  input  wire psi_pkg::psi_pat_t patSel,
  input  wire logic              updateDone,
  input  wire logic              ioWr,
  input  wire logic              ioRd,
  input  wire logic [15:0]       ioAddr,
  input  wire logic [7:0]        ioWrData,
  output logic [7:0]             ioRdData_q,
  output logic [7:0]             progressCode_q,
  output logic                   spkOut,
  output logic                   ledOut_q,
  output logic                   shutdownReq_q,
  output logic                   patBusy_q
);
  import psi_pkg::*;

  psi_pat_t    pat_q;
  logic [24:0] quarterCnt_q;
  logic [5:0]  qCnt_q;
  logic        vidToneDone_q;
  logic        repOdd_q;

  wire tick     = (quarterCnt_q == 25'(QUARTER_CYCLES - 1));
  wire codeHit  = (ioAddr == CODE_ADDR);
  wire [5:0] blinkPos = qCnt_q & (BLINK_PERIOD - 6'h01);
  wire blinkOn  = (blinkPos < 6'h04);

  // last quarter of the current pattern cycle
  wire [5:0] lastQ =
    (pat_q == PSI_PROMPT)  ? PROMPT_LAST  :
    (pat_q == PSI_UPDATE)  ? UPDATE_LAST  :
    (pat_q == PSI_VIDEO)   ? VIDEO_LAST   :
    (pat_q == PSI_MEMORY)  ? MEMORY_LAST  : THERMAL_LAST;
  wire cycleEnd = tick && (qCnt_q == lastQ);

  wire vidOn = (qCnt_q < VIDEO_BLINKS) && blinkOn;
  wire memOn = (qCnt_q < MEMORY_BLINKS) && blinkOn;

  psi_tone_t toneSel;
  assign toneSel =
    (pat_q == PSI_PROMPT)                   ? PSI_TONE_BEEP :
    (pat_q == PSI_VIDEO && !vidToneDone_q
      && vidOn)                             ? PSI_TONE_BEEP :
    (pat_q == PSI_MEMORY && memOn)          ? PSI_TONE_BEEP :
    (pat_q == PSI_THERMAL && !qCnt_q[2])    ? PSI_TONE_HIGH :
    (pat_q == PSI_THERMAL)                  ? PSI_TONE_LOW  :
                                              PSI_TONE_OFF;

  wire ledD =
    (pat_q == PSI_UPDATE)  ? qCnt_q[1]   :
    (pat_q == PSI_VIDEO)   ? vidOn       :
    (pat_q == PSI_MEMORY)  ? memOn       :
    (pat_q == PSI_THERMAL) ? !qCnt_q[0]  :
                             1'b0;

  wire [23:0] halfPeriod =
    (toneSel == PSI_TONE_HIGH) ? 24'(HALF_HIGH_CYC) :
    (toneSel == PSI_TONE_LOW)  ? 24'(HALF_LOW_CYC)  :
                                 24'(HALF_BEEP_CYC);

  // one-shot patterns return to idle; the endless ones wrap
  psi_pat_t patD;
  always_comb begin
    patD = pat_q;
    if (patReq) begin
      patD = patSel;
    end else if (cycleEnd) begin
      case (pat_q)
        PSI_PROMPT:  patD = PSI_IDLE;
        PSI_THERMAL: patD = PSI_IDLE;
        default:     patD = pat_q;
      endcase
    end
    if (!patReq && pat_q == PSI_UPDATE && updateDone) begin
      patD = PSI_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || patReq || tick) begin
      quarterCnt_q <= 25'h0000000;
    end else begin
      quarterCnt_q <= quarterCnt_q + 25'h0000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || patReq || cycleEnd) begin
      qCnt_q <= 6'h00;
    end else if (tick) begin
      qCnt_q <= qCnt_q + 6'h01;
    end
  end

  // the video tone sequence plays twice; the blinks carry on alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst || patReq) begin
      vidToneDone_q <= 1'b0;
    end else if (pat_q == PSI_VIDEO && cycleEnd && qCnt_q == VIDEO_LAST) begin
      vidToneDone_q <= vidToneDone_q | repOdd_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || patReq) begin
      repOdd_q <= 1'b0;
    end else if (pat_q == PSI_VIDEO && cycleEnd) begin
      repOdd_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pat_q         <= PSI_IDLE;
      ledOut_q      <= 1'b0;
      shutdownReq_q <= 1'b0;
      patBusy_q     <= 1'b0;
    end else begin
      pat_q         <= patD;
      ledOut_q      <= ledD;
      shutdownReq_q <= shutdownReq_q
                       || (pat_q == PSI_THERMAL && cycleEnd);
      patBusy_q     <= (patD != PSI_IDLE);
    end
  end

  // holds the last progress code; nothing but a new write or a reset changes it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      progressCode_q <= CODE_RESET;
      ioRdData_q     <= 8'h00;
    end else begin
      if (ioWr && codeHit) begin
        progressCode_q <= ioWrData;
      end
      ioRdData_q <= (ioRd && codeHit) ? progressCode_q : 8'h00;
    end
  end

  psi_tone_gen u_tone (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .toneEn     (toneSel != PSI_TONE_OFF),
    .halfPeriod (halfPeriod),
    .toneOut_q  (spkOut)
  );

  code_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ioWr && codeHit |=> progressCode_q == $past(ioWrData))
    else $error("progress code not latched");
  code_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(ioWr && codeHit) |=> $stable(progressCode_q))
    else $error("progress code changed without write");
  prompt_beep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_PROMPT |-> toneSel == PSI_TONE_BEEP && !ledD)
    else $error("prompt pattern wrong");
  prompt_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_PROMPT && tick && qCnt_q == 6'h01 && !patReq
    |=> pat_q == PSI_IDLE)
    else $error("prompt beep length wrong");
  update_led_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_UPDATE |-> toneSel == PSI_TONE_OFF && ledD == qCnt_q[1])
    else $error("update blink wrong");
  video_gap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_VIDEO && qCnt_q >= 6'h10 |-> !ledD
    && toneSel == PSI_TONE_OFF)
    else $error("video pause not dark");
  video_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_VIDEO && vidToneDone_q |-> toneSel == PSI_TONE_OFF)
    else $error("video beeps beyond two rounds");
  memory_wrap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_MEMORY && tick && qCnt_q == 6'h21 && !patReq
    |=> pat_q == PSI_MEMORY && qCnt_q == 6'h00)
    else $error("memory pattern did not repeat");
  memory_blink_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_MEMORY && qCnt_q < 6'h18 |-> ledD == !qCnt_q[2]
    && (toneSel == PSI_TONE_BEEP) == ledD)
    else $error("memory blink wrong");
  thermal_tone_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_THERMAL |-> toneSel == (qCnt_q[2] ? PSI_TONE_LOW
    : PSI_TONE_HIGH) && ledD == !qCnt_q[0])
    else $error("thermal tone or blink wrong");
  thermal_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_THERMAL && tick && qCnt_q == 6'h1f && !patReq
    |=> shutdownReq_q && pat_q == PSI_IDLE)
    else $error("thermal shutdown missing");
  replace_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    patReq |=> pat_q == $past(patSel) && qCnt_q == 6'h00)
    else $error("new request did not replace pattern");

  prompt_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_PROMPT ##1 pat_q == PSI_IDLE);
  memory_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    pat_q == PSI_MEMORY && cycleEnd);
  thermal_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(shutdownReq_q));
  video_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(vidToneDone_q));

endmodule // psi_indicator

// File: psi_far_side.sv
// speaker, power LED and code display card seen from the board pins
`timescale 1ns/100ps
module psi_far_side (
  input  wire logic       sys_clk,
  input  wire logic       spkIn,
  input  wire logic       ledIn,
  input  wire logic [7:0] codeIn,
  output int              toggleCnt,
  output int              ledOnCnt,
  output logic [7:0]      shownCode
);
  logic spkLast;
  initial begin
    spkLast   = 1'b0;
    toggleCnt = 0;
    ledOnCnt  = 0;
  end
  // each level change moves the speaker cone once
  always @(posedge sys_clk) begin
    if (spkIn === ~spkLast) toggleCnt++;
    spkLast = spkIn;
    if (ledIn === 1'b1) ledOnCnt++;
    shownCode = codeIn;
  end
endmodule // psi_far_side

// File: tb_psi_indicator.sv
// self-checking bench for the beep, blink and progress code block
`timescale 1ns/100ps
module tb_psi_indicator;
  import psi_pkg::*;
  localparam int Q = 40;
  logic sys_clk, sys_rst, patReq, updateDone, ioWr, ioRd, spkOut, ledOut_q;
  logic shutdownReq_q, patBusy_q;
  psi_pat_t patSel;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData_q, progressCode_q, shownCode;
  int toggleCnt, ledOnCnt, tg, ld, mismatches = 0, nTests = 0;
  // firmware codes kept inside the allowed categories
  logic [7:0] codes [7] = '{
    8'h1f,
    8'h2f,
    8'h3f,
    8'hd0,
    8'h7f,
    8'hef,
    8'hff
  };

  psi_indicator #(.QUARTER_CYCLES(Q), .HALF_BEEP_CYC(3), .HALF_HIGH_CYC(4),
    .HALF_LOW_CYC(5)) i_psi_indicator (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .patReq(patReq), .patSel(patSel), .updateDone(updateDone), .ioWr(ioWr),
    .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioRdData_q(ioRdData_q), .progressCode_q(progressCode_q),
    .spkOut(spkOut), .ledOut_q(ledOut_q), .shutdownReq_q(shutdownReq_q),
    .patBusy_q(patBusy_q));
  psi_far_side i_psi_far_side (.sys_clk(sys_clk), .spkIn(spkOut),
    .ledIn(ledOut_q), .codeIn(progressCode_q), .toggleCnt(toggleCnt),
    .ledOnCnt(ledOnCnt), .shownCode(shownCode));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic closeOut();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // counts may differ by a few cycles at pattern edges, hence the tolerance
  task automatic near(input int got, input int exp, input int tol,
                      input string what);
    nTests++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic same(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    nTests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic ioAccess(input logic wr, input logic [15:0] a,
                          input logic [7:0] d);
    @(negedge sys_clk);
    ioWr = wr;
    ioRd = ~wr;
    ioAddr = a;
    ioWrData = d;
    @(negedge sys_clk);
    ioWr = 1'b0;
    ioRd = 1'b0;
  endtask

  task automatic start(input psi_pat_t sel);
    @(negedge sys_clk);
    patReq = 1'b1;
    patSel = sel;
    @(negedge sys_clk);
    patReq = 1'b0;
  endtask

  task automatic window(input int cyc);
    int t0, l0;
    t0 = toggleCnt;
    l0 = ledOnCnt;
    repeat (cyc) @(negedge sys_clk);
    tg = toggleCnt - t0;
    ld = ledOnCnt - l0;
  endtask

  task automatic test_code();
    same(progressCode_q, CODE_RESET, "reset code");
    foreach (codes[k]) begin
      ioAccess(1'b1, 16'h0080, codes[k]);
      same(progressCode_q, codes[k], "code latch");
    end
    ioAccess(1'b1, 16'h0081, 8'h5f);
    same(shownCode, 8'hff, "unmapped write");
    ioAccess(1'b0, 16'h0080, 8'h00);
    same(ioRdData_q, 8'hff, "code read");
    ioAccess(1'b0, 16'h0081, 8'h00);
    same(ioRdData_q, 8'h00, "unmapped read");
  endtask

  task automatic test_prompt();
    start(PSI_PROMPT);
    same({7'h0, patBusy_q}, 8'h01, "prompt busy");
    window(3 * Q);
    near(tg, 2 * Q / 3, 2, "prompt tone");
    near(ld, 0, 0, "prompt led");
    same({7'h0, patBusy_q}, 8'h00, "prompt ends");
  endtask

  task automatic test_update();
    start(PSI_UPDATE);
    window(2 * Q);
    near(ld, 0, 1, "update first dark");
    window(6 * Q);
    near(ld, 4 * Q, 2, "update blink");
    near(tg, 0, 0, "update silent");
    @(negedge sys_clk) updateDone = 1'b1;
    @(negedge sys_clk) updateDone = 1'b0;
    window(4 * Q);
    near(ld, 0, 1, "update done");
  endtask

  task automatic test_video();
    start(PSI_VIDEO);
    repeat (2) begin
      window(26 * Q);
      near(tg, 8 * Q / 3, 3, "video tone");
    end
    window(26 * Q);
    near(tg, 0, 1, "video tone over");
    near(ld, 8 * Q, 2, "video blink");
    start(PSI_IDLE);
    window(2 * Q);
    near(ld, 0, 1, "stop led");
    near(tg, 0, 0, "stop tone");
    same({7'h0, patBusy_q}, 8'h00, "stop idle");
  endtask

  task automatic test_memory();
    start(PSI_MEMORY);
    repeat (2) begin
      window(34 * Q);
      near(tg, 12 * Q / 3, 3, "memory tone");
      near(ld, 12 * Q, 2, "memory blink");
    end
    start(PSI_PROMPT);
    window(3 * Q);
    near(ld, 0, 1, "replaced led");
    near(tg, 2 * Q / 3, 3, "replaced tone");
  endtask

  task automatic test_thermal();
    start(PSI_THERMAL);
    window(4 * Q);
    near(tg, Q, 2, "high tone");
    near(ld, 2 * Q, 2, "thermal blink");
    window(4 * Q);
    near(tg, 4 * Q / 5, 2, "low tone");
    window(25 * Q);
    near(ld, 12 * Q, 2, "thermal blinks");
    same({7'h0, shutdownReq_q}, 8'h01, "shutdown");
    same({7'h0, patBusy_q}, 8'h00, "thermal ends");
  endtask

  // a second reset in mid-run must clear the sticky shutdown and the code
  task automatic test_reset();
    @(negedge sys_clk) sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    same({7'h0, shutdownReq_q}, 8'h00, "reset shutdown");
    same(progressCode_q, CODE_RESET, "reset code again");
    same({7'h0, patBusy_q}, 8'h00, "reset idle");
  endtask

  initial begin
    {patReq, updateDone, ioWr, ioRd, ioAddr, ioWrData} = '0;
    patSel = PSI_IDLE;
    sys_rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    sys_rst = 1'b0;
    test_code();
    test_prompt();
    test_update();
    test_video();
    test_memory();
    test_thermal();
    test_reset();
    closeOut();
  end

  // all scenarios together need about 8000 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    closeOut();
  end
endmodule // tb_psi_indicator
